// >>> logic/frc_defines.svh
`ifndef FRC_DEFINES_SVH
`define FRC_DEFINES_SVH
`define FRC_IDX_MODE     8'h10
`define FRC_IDX_SYSF     8'h12
`define FRC_IDX_TIME     8'h16
`define FRC_IDX_CFG      8'h20
`define FRC_IDX_STAT     8'h21
`define FRC_RST_MODE     16'h0115
`define FRC_RST_SYSF     16'h0515
`define FRC_RST_TIME     16'h0003
`define FRC_RST_CFG      16'h0000
`define FRC_WM_MODE      16'h01FF
`define FRC_WM_SYSF      16'h0635
`define FRC_WM_TIME      16'h000F
`define FRC_WM_CFG       16'h0001
`define FRC_BIT_PAR      15
`define FRC_BIT_OTPDIS   8
`define FRC_BIT_SPIDIS   7
`define FRC_OC_HI        6
`define FRC_OC_LO        4
`define FRC_UV_HI        3
`define FRC_UV_LO        2
`define FRC_OT_HI        1
`define FRC_OT_LO        0
`define FRC_BIT_OTAVDD   10
`define FRC_BIT_OTW      9
`define FRC_BIT_CSAREF   5
`define FRC_SLOW_HI      3
`define FRC_SLOW_LO      2
`define FRC_RETRY_MS0    500
`define FRC_RETRY_MS1    1000
`define FRC_RETRY_MS2    2000
`define FRC_RETRY_MS3    5000
`define FRC_CLK_KHZ      100000
`endif

// >>> logic/frc_pkg.sv
package frc_pkg;
  typedef enum logic [2:0] {
    FRC_OC_SLOW, FRC_OC_FAST, FRC_OC_LATCH, FRC_OC_REPORT,
    FRC_OC_RSV4, FRC_OC_RSV5, FRC_OC_RSV6, FRC_OC_OFF
  } frc_oc_mode_t;
  typedef struct packed {
    logic report;
    logic hiz;
    logic retry;
    logic fast;
    logic latch;
  } frc_action_t;
endpackage

// >>> logic/frc_fault_response_config.sv
// Design decision made here: register access over APB.
`timescale 1ns/10ps
`include "frc_defines.svh"
// Function
// - Bit 15 returns parity when parity enabled
// - Mode bit 8 disables OTP fault, resets 1
// - Mode bit 7 disables serial fault, resets 0
// - Overcurrent field 6-4: slow, fast, disabled
// - Overcurrent code 2 latches predriver off
// - Overcurrent code 3 reports only
// - Undervoltage field 3-2: slow or fast retry
// - Overtemperature field 1-0: slow or fast retry
// - System bit 10 enables regulator overtemperature
// - System bit 9 gates warning reporting
// - Sense reference undervoltage enable, resets 0
// - Slow retry interval chosen by two bits
module frc_fault_response_config #(
  parameter int          ADDR_W       = 8,
  parameter logic [31:0] RETRY0_CYC   = 32'(`FRC_RETRY_MS0 * `FRC_CLK_KHZ),
  parameter logic [31:0] RETRY1_CYC   = 32'(`FRC_RETRY_MS1 * `FRC_CLK_KHZ),
  parameter logic [31:0] RETRY2_CYC   = 32'(`FRC_RETRY_MS2 * `FRC_CLK_KHZ),
  parameter logic [31:0] RETRY3_CYC   = 32'(`FRC_RETRY_MS3 * `FRC_CLK_KHZ)
) (
  input  wire logic              CORE_CLK,
  input  wire logic              RSTN,
  input  wire logic              CORE_CE,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic [31:0]            PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic              OC_DETECT,
  input  wire logic              UV_DETECT,
  input  wire logic              OT_DETECT,
  input  wire logic              OTW_DETECT,
  input  wire logic              OTP_READ_ERR,
  input  wire logic              SERIAL_ERR,
  output logic                   FAULT_INDICATOR_N,
  output logic                   PREDRV_HIZ,
  output logic                   OC_RETRY,
  output logic                   OC_RETRY_FAST,
  output logic                   UV_RETRY_FAST,
  output logic                   OT_RETRY_FAST,
  output logic [31:0]            SLOW_RETRY_CYCLES,
  output logic                   REG_OVERTEMP_EN,
  output logic                   SENSE_REF_UV_EN
);

  logic              rst_meta_r;
  logic              rst_n_r;
  logic [15:0]       mode_r;
  logic [15:0]       sysf_r;
  logic [15:0]       time_r;
  logic [15:0]       cfg_r;
  logic              oc_latched_r;
  logic [31:0]       prdata_r;
  logic              pslverr_r;
  logic [ADDR_W-3:0] idx;
  logic              setup;
  logic              acc;
  logic              wr_acc;
  logic              mapped;
  logic [15:0]       rd_word;
  logic              latch_clr;
  frc_pkg::frc_oc_mode_t oc_mode;
  frc_pkg::frc_action_t  oc_act;
  logic              oc_fault;
  logic              any_report;
  logic              any_hiz;

  // Reset is asserted at once but released through two flops to avoid a ragged release.
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  function automatic logic [15:0] frc_par(input logic [15:0] w, input logic en);
    frc_par = {en & (^w[14:0]), w[14:0]};
  endfunction

  function automatic logic [15:0] frc_merge(input logic [15:0] q, input logic [15:0] rv,
                                            input logic [15:0] wm);
    frc_merge = ((q & wm) | (rv & ~wm)) & 16'h7FFF;
  endfunction

  function automatic frc_pkg::frc_action_t frc_retry_act(input logic code0);
    frc_retry_act = '{report: 1'b1, hiz: 1'b1, retry: 1'b1, fast: code0, latch: 1'b0};
  endfunction

  assign idx    = PADDR[ADDR_W-1:2];
  assign setup  = PSEL & ~PENABLE;
  assign acc    = PSEL & PENABLE;
  assign wr_acc = acc & PWRITE & CORE_CE;
  assign mapped = (idx == `FRC_IDX_MODE) || (idx == `FRC_IDX_SYSF) || (idx == `FRC_IDX_TIME) ||
                  (idx == `FRC_IDX_CFG) || (idx == `FRC_IDX_STAT);

  always_comb begin
    rd_word = 16'h0000;
    unique case (idx)
      `FRC_IDX_MODE: rd_word = frc_merge(mode_r, `FRC_RST_MODE, `FRC_WM_MODE);
      `FRC_IDX_SYSF: rd_word = frc_merge(sysf_r, `FRC_RST_SYSF, `FRC_WM_SYSF);
      `FRC_IDX_TIME: rd_word = frc_merge(time_r, `FRC_RST_TIME, `FRC_WM_TIME);
      `FRC_IDX_CFG:  rd_word = frc_merge(cfg_r, `FRC_RST_CFG, `FRC_WM_CFG);
      `FRC_IDX_STAT: rd_word = {9'h000, SERIAL_ERR, OTP_READ_ERR, OTW_DETECT, OT_DETECT,
                                UV_DETECT, OC_DETECT, oc_latched_r};
      default:       rd_word = 16'h0000;
    endcase
  end

  // Read data is captured in the setup cycle, so the access phase can end in its first cycle.
  always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (CORE_CE && setup) begin
      prdata_r  <= PWRITE ? 32'h0000_0000 : {16'h0000, frc_par(rd_word, cfg_r[0])};
      pslverr_r <= ~mapped;
    end
  end

  assign PRDATA  = prdata_r;
  assign PREADY  = 1'b1;
  assign PSLVERR = pslverr_r & acc;

  always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mode_r <= `FRC_RST_MODE;
    end else if (wr_acc && idx == `FRC_IDX_MODE) begin
      mode_r <= PWDATA[15:0] & `FRC_WM_MODE;
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sysf_r <= `FRC_RST_SYSF;
    end else if (wr_acc && idx == `FRC_IDX_SYSF) begin
      sysf_r <= PWDATA[15:0] & `FRC_WM_SYSF;
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      time_r <= `FRC_RST_TIME;
    end else if (wr_acc && idx == `FRC_IDX_TIME) begin
      time_r <= PWDATA[15:0] & `FRC_WM_TIME;
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cfg_r <= `FRC_RST_CFG;
    end else if (wr_acc && idx == `FRC_IDX_CFG) begin
      cfg_r <= PWDATA[15:0] & `FRC_WM_CFG;
    end
  end

  assign oc_mode  = frc_pkg::frc_oc_mode_t'(mode_r[`FRC_OC_HI:`FRC_OC_LO]);
  assign oc_fault = OC_DETECT & (oc_mode != frc_pkg::FRC_OC_OFF);

  always_comb begin
    oc_act = '0;
    unique case (oc_mode)
      frc_pkg::FRC_OC_SLOW:   oc_act = frc_retry_act(1'b0);
      frc_pkg::FRC_OC_FAST:   oc_act = frc_retry_act(1'b1);
      frc_pkg::FRC_OC_LATCH:  oc_act = '{report: 1'b1, hiz: 1'b1, retry: 1'b0, fast: 1'b0, latch: 1'b1};
      frc_pkg::FRC_OC_REPORT: oc_act = '{report: 1'b1, hiz: 1'b0, retry: 1'b0, fast: 1'b0, latch: 1'b0};
      default:                oc_act = '0;
    endcase
  end

  // A latched overcurrent stays until software writes one to status bit 0 or the overcurrent mode leaves latch; a new fault wins.
  assign latch_clr = wr_acc && idx == `FRC_IDX_STAT && PWDATA[0];

  always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      oc_latched_r <= 1'b0;
    end else if (CORE_CE) begin
      if (OC_DETECT && oc_act.latch) begin
        oc_latched_r <= 1'b1;
      end else if (latch_clr || !oc_act.latch) begin
        oc_latched_r <= 1'b0;
      end
    end
  end

  assign any_report = (oc_fault & oc_act.report) | oc_latched_r | UV_DETECT | OT_DETECT |
                      (OTW_DETECT & sysf_r[`FRC_BIT_OTW]) |
                      (OTP_READ_ERR & ~mode_r[`FRC_BIT_OTPDIS]) |
                      (SERIAL_ERR & ~mode_r[`FRC_BIT_SPIDIS]);
  assign any_hiz    = (oc_fault & oc_act.hiz) | oc_latched_r | UV_DETECT | OT_DETECT;

  // Outputs are registered so the pins never glitch while a register write settles.
  always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      FAULT_INDICATOR_N <= 1'b1;
      PREDRV_HIZ        <= 1'b0;
      OC_RETRY          <= 1'b1;
      OC_RETRY_FAST     <= 1'b1;
      UV_RETRY_FAST     <= 1'b1;
      OT_RETRY_FAST     <= 1'b1;
      REG_OVERTEMP_EN   <= 1'b1;
      SENSE_REF_UV_EN   <= 1'b0;
    end else if (CORE_CE) begin
      FAULT_INDICATOR_N <= ~any_report;
      PREDRV_HIZ        <= any_hiz;
      OC_RETRY          <= oc_act.retry;
      OC_RETRY_FAST     <= oc_act.fast;
      UV_RETRY_FAST     <= mode_r[`FRC_UV_LO];
      OT_RETRY_FAST     <= mode_r[`FRC_OT_LO];
      REG_OVERTEMP_EN   <= sysf_r[`FRC_BIT_OTAVDD];
      SENSE_REF_UV_EN   <= sysf_r[`FRC_BIT_CSAREF];
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      SLOW_RETRY_CYCLES <= RETRY0_CYC;
    end else if (CORE_CE) begin
      unique case (time_r[`FRC_SLOW_HI:`FRC_SLOW_LO])
        2'h0: SLOW_RETRY_CYCLES <= RETRY0_CYC;
        2'h1: SLOW_RETRY_CYCLES <= RETRY1_CYC;
        2'h2: SLOW_RETRY_CYCLES <= RETRY2_CYC;
        2'h3: SLOW_RETRY_CYCLES <= RETRY3_CYC;
      endcase
    end
  end

  default clocking frc_cb @(posedge CORE_CLK); endclocking
  default disable iff (!rst_n_r);

  parity_read_a: assert property (CORE_CE && setup && !PWRITE |=>
    PRDATA[15] == (cfg_r[0] & (^PRDATA[14:0])))
    else $error("Read parity bit wrong.");
  otp_gate_a: assert property (CORE_CE && OTP_READ_ERR && !mode_r[8] |=> !FAULT_INDICATOR_N)
    else $error("Enabled OTP fault not reported.");
  serial_gate_a: assert property (CORE_CE && SERIAL_ERR && mode_r[7] && !OC_DETECT && !UV_DETECT &&
    !OT_DETECT && !OTW_DETECT && !OTP_READ_ERR && !oc_latched_r |=> FAULT_INDICATOR_N)
    else $error("Disabled serial fault reported.");
  oc_disable_a: assert property (CORE_CE && mode_r[6:4] == 3'h7 && OC_DETECT && !UV_DETECT &&
    !OT_DETECT && !oc_latched_r |=> !PREDRV_HIZ)
    else $error("Disabled overcurrent acted.");
  oc_latch_a: assert property (CORE_CE && OC_DETECT && mode_r[6:4] == 3'h2 ##1 CORE_CE && !latch_clr
    && mode_r[6:4] == 3'h2 |=> oc_latched_r && PREDRV_HIZ)
    else $error("Overcurrent latch not held.");
  oc_report_a: assert property (CORE_CE && mode_r[6:4] == 3'h3 && OC_DETECT && !UV_DETECT &&
    !OT_DETECT && !oc_latched_r |=> !FAULT_INDICATOR_N && !PREDRV_HIZ)
    else $error("Report-only overcurrent wrong.");
  uv_fast_a: assert property (CORE_CE |=> UV_RETRY_FAST == $past(mode_r[2]))
    else $error("Undervoltage retry speed wrong.");
  ot_fast_a: assert property (CORE_CE |=> OT_RETRY_FAST == $past(mode_r[0]))
    else $error("Overtemperature retry speed wrong.");
  reg_ot_a: assert property (wr_acc && idx == `FRC_IDX_SYSF ##1 CORE_CE |=>
    REG_OVERTEMP_EN == $past(PWDATA[10], 2))
    else $error("Regulator overtemperature enable wrong.");
  otw_gate_a: assert property (CORE_CE && OTW_DETECT && sysf_r[9] |=> !FAULT_INDICATOR_N)
    else $error("Warning not reported.");
  sense_uv_a: assert property (wr_acc && idx == `FRC_IDX_SYSF ##1 CORE_CE |=>
    SENSE_REF_UV_EN == $past(PWDATA[5], 2))
    else $error("Sense reference enable wrong.");
  slow_sel_a: assert property (CORE_CE && time_r[3:2] == 2'h3 |=> SLOW_RETRY_CYCLES == RETRY3_CYC)
    else $error("Slow retry interval wrong.");
  parity_off_a: assert property (CORE_CE && setup && !PWRITE && !cfg_r[0] |=> !PRDATA[15])
    else $error("Parity bit set while disabled.");
  otp_mask_a: assert property (CORE_CE && OTP_READ_ERR && mode_r[8] && !OC_DETECT && !UV_DETECT &&
    !OT_DETECT && !OTW_DETECT && !SERIAL_ERR && !oc_latched_r |=> FAULT_INDICATOR_N)
    else $error("Disabled OTP fault reported.");
  oc_slow_a: assert property (CORE_CE && mode_r[6:4] == 3'h0 |=> OC_RETRY && !OC_RETRY_FAST)
    else $error("Slow overcurrent retry wrong.");
  oc_fast_a: assert property (CORE_CE && mode_r[6:4] == 3'h1 |=> OC_RETRY && OC_RETRY_FAST)
    else $error("Fast overcurrent retry wrong.");
  mode_store_a: assert property (wr_acc && idx == `FRC_IDX_MODE |=>
    mode_r == ($past(PWDATA[15:0]) & `FRC_WM_MODE))
    else $error("Mode register write wrong.");
  latch_clear_a: assert property (CORE_CE && latch_clr && !OC_DETECT |=> !oc_latched_r)
    else $error("Overcurrent latch not cleared.");
  latch_wins_a: assert property (CORE_CE && OC_DETECT && mode_r[6:4] == 3'h2 |=> oc_latched_r)
    else $error("Overcurrent latch not set.");
  uv_hiz_a: assert property (CORE_CE && UV_DETECT |=> !FAULT_INDICATOR_N && PREDRV_HIZ)
    else $error("Undervoltage response wrong.");
  ot_hiz_a: assert property (CORE_CE && OT_DETECT |=> !FAULT_INDICATOR_N && PREDRV_HIZ)
    else $error("Overtemperature response wrong.");
  otw_mask_a: assert property (CORE_CE && OTW_DETECT && !sysf_r[9] && !OC_DETECT && !UV_DETECT &&
    !OT_DETECT && !OTP_READ_ERR && !SERIAL_ERR && !oc_latched_r |=> FAULT_INDICATOR_N)
    else $error("Disabled warning reported.");
  ce_freeze_a: assert property (!CORE_CE |=> $stable(mode_r) && $stable(sysf_r) &&
    $stable(time_r) && $stable(cfg_r))
    else $error("Registers changed while frozen.");
  unmapped_err_a: assert property (CORE_CE && setup && !mapped ##1 acc |-> PSLVERR)
    else $error("Unmapped access not flagged.");

  mode_write_c: cover property (wr_acc && idx == `FRC_IDX_MODE);
  latch_clear_c: cover property (oc_latched_r ##1 !oc_latched_r);
  parity_read_c: cover property (CORE_CE && setup && !PWRITE && cfg_r[0]);
  unmapped_c: cover property (PSLVERR);
  oc_report_c: cover property (CORE_CE && mode_r[6:4] == 3'h3 && OC_DETECT);

endmodule

// >>> test/frc_fault_response_config_bench.sv
`timescale 1ns/10ps
module frc_fault_response_config_bench;
  localparam logic [31:0] RT [4] = '{32'h0000_000A, 32'h0000_0014, 32'h0000_0028, 32'h0000_0064};
  logic        clk      = 1'b0;
  logic        rstn     = 1'b0;
  logic        ce       = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0000_0000;
  logic [5:0]  det      = 6'h00;
  logic [31:0] prdata;
  logic [31:0] slow;
  logic        pready;
  logic        pslverr;
  logic        fault_n;
  logic        hiz;
  logic        ocr;
  logic        ocf;
  logic        uvf;
  logic        otf;
  logic        roe;
  logic        sre;
  logic [31:0] rd;
  logic        er;
  logic [15:0] v;
  logic [2:0]  codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  int          errors   = 0;
  int          n_checks = 0;
  int          cyc      = 0;
  integer      seed     = 32'hbda4_2649;

  // Short retry counts keep the run brief; expectations use the same table.
  frc_fault_response_config #(.RETRY0_CYC(RT[0]), .RETRY1_CYC(RT[1]), .RETRY2_CYC(RT[2]),
    .RETRY3_CYC(RT[3])) DUT (.CORE_CLK(clk), .RSTN(rstn), .CORE_CE(ce), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .OC_DETECT(det[0]), .UV_DETECT(det[1]),
    .OT_DETECT(det[3]), .OTW_DETECT(det[2]), .OTP_READ_ERR(det[4]), .SERIAL_ERR(det[5]),
    .FAULT_INDICATOR_N(fault_n), .PREDRV_HIZ(hiz), .OC_RETRY(ocr), .OC_RETRY_FAST(ocf),
    .UV_RETRY_FAST(uvf), .OT_RETRY_FAST(otf), .SLOW_RETRY_CYCLES(slow),
    .REG_OVERTEMP_EN(roe), .SENSE_REF_UV_EN(sre));

  always #5 clk = ~clk;

  function automatic logic [31:0] par(input logic [15:0] x);
    return {16'h0000, ^x[14:0], x[14:0]};
  endfunction

  task automatic results;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      results;
    end
  end

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string m);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask

  // The release is followed by an idle edge so that no signal is driven twice in one step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string m);
    apb(1'b0, a, 32'h0000_0000);
    chk_reg(rd, e, m);
  endtask

  task automatic settle;
    repeat (3) @(posedge clk);
  endtask

  // The long idle after each fault lets any retry interval run out before the next case.
  task automatic hit(input int k, input logic efn, input logic ehiz);
    det <= 6'(1 << k);
    settle;
    chk_bit(fault_n, efn, "fault indicator");
    if (ehiz !== 1'bx)
      chk_bit(hiz, ehiz, "predriver hiz");
    det <= 6'h00;
    repeat (150) @(posedge clk);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk_bit(ocr, 1'b1, "oc retry reset");
    chk_bit(ocf, 1'b1, "oc fast reset");
    chk_bit(uvf, 1'b1, "uv fast reset");
    chk_bit(otf, 1'b1, "ot fast reset");
    chk_bit(roe, 1'b1, "reg ot reset");
    chk_bit(sre, 1'b0, "sense ref reset");
    chk_reg(slow, RT[0], "slow reset");
    rdchk(8'h40, 32'h0000_0115, "mode reset");
    rdchk(8'h48, 32'h0000_0515, "system reset");
    rdchk(8'h58, 32'h0000_0003, "timing reset");
    apb(1'b0, 8'h44, 32'h0000_0000);
    chk_bit(er, 1'b1, "unmapped error");
    chk_reg(rd, 32'h0000_0000, "unmapped data");
    wr(8'h48, 32'h0000_0415);
    rdchk(8'h48, 32'h0000_0515, "system read-only bit");
    for (int i = 0; i < 10; i++) begin
      v = 16'($random(seed)) & 16'h0185;
      v[6:4] = codes[i % 5];
      wr(8'h40, {16'h0000, v});
      rdchk(8'h40, {16'h0000, v}, "mode readback");
      settle;
      chk_bit(ocr, v[6:4] < 3'h2, "oc retry");
      chk_bit(ocf, v[6:4] == 3'h1, "oc fast");
      chk_bit(uvf, v[2], "uv fast");
      chk_bit(otf, v[0], "ot fast");
    end
    for (int i = 0; i < 4; i++) begin
      v = 16'h0115 | (16'($random(seed)) & 16'h0620);
      wr(8'h48, {16'h0000, v});
      rdchk(8'h48, {16'h0000, v}, "system readback");
      settle;
      chk_bit(roe, v[10], "reg ot enable");
      chk_bit(sre, v[5], "sense ref enable");
    end
    for (int s = 0; s < 4; s++) begin
      wr(8'h58, {28'h000_0000, 2'(s), 2'h3});
      rdchk(8'h58, {28'h000_0000, 2'(s), 2'h3}, "timing readback");
      settle;
      chk_reg(slow, RT[s], "slow interval");
    end
    ce <= 1'b0;
    wr(8'h58, 32'h0000_0000);
    ce <= 1'b1;
    rdchk(8'h58, 32'h0000_000F, "frozen write");
    wr(8'h48, 32'h0000_0515);
    wr(8'h80, 32'h0000_0001);
    rdchk(8'h80, 32'h0000_8001, "config parity");
    rdchk(8'h48, par(16'h0515), "system parity");
    wr(8'h80, 32'h0000_0000);
    rdchk(8'h48, 32'h0000_0515, "parity off");
    wr(8'h40, 32'h0000_0071);
    hit(0, 1'b1, 1'b0);
    hit(5, 1'b0, 1'bx);
    hit(4, 1'b0, 1'bx);
    hit(2, 1'b1, 1'bx);
    hit(1, 1'b0, 1'b1);
    hit(3, 1'b0, 1'b1);
    wr(8'h40, 32'h0000_01F1);
    hit(5, 1'b1, 1'bx);
    hit(4, 1'b1, 1'bx);
    wr(8'h48, 32'h0000_0715);
    hit(2, 1'b0, 1'bx);
    wr(8'h40, 32'h0000_0031);
    hit(0, 1'b0, 1'b0);
    wr(8'h40, 32'h0000_0001);
    hit(0, 1'b0, 1'b1);
    wr(8'h40, 32'h0000_0011);
    hit(0, 1'b0, 1'b1);
    wr(8'h40, 32'h0000_0021);
    det[0] <= 1'b1;
    settle;
    chk_bit(hiz, 1'b1, "latch set");
    det[0] <= 1'b0;
    repeat (40) @(posedge clk);
    chk_bit(hiz, 1'b1, "latch held");
    rdchk(8'h84, 32'h0000_0001, "latch status");
    wr(8'h84, 32'h0000_0001);
    settle;
    chk_bit(hiz, 1'b0, "latch cleared");
    wr(8'h58, 32'h0000_0008);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk_reg(slow, RT[0], "slow after reset");
    chk_bit(hiz, 1'b0, "hiz after reset");
    rdchk(8'h40, 32'h0000_0115, "mode after reset");
    results;
  end
endmodule
